// >>> verilog/psrfs_map.vh
// constants for the primary-side fault supervisor
`ifndef PSRFS_MAP_VH
`define PSRFS_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define PSRFS_ADDR_W        4
`define PSRFS_REG_STATUS    4'h0
`define PSRFS_REG_CLEAR     4'h1
`define PSRFS_REG_ENABLE    4'h2
`define PSRFS_REG_STATE     4'h3
`define PSRFS_REG_CTRL      4'h4

// ****************************************
// event bit positions
// ****************************************
`define PSRFS_EV_W          8
`define PSRFS_EV_OVP        0
`define PSRFS_EV_UVP        1
`define PSRFS_EV_SHORT      2
`define PSRFS_EV_SAT        3
`define PSRFS_EV_OTP        4
`define PSRFS_EV_OUTPUT_OVERVOLTAGE_PROTECT       5
`define PSRFS_EV_BROWNOUT   6
`define PSRFS_EV_BROWNIN    7

// ****************************************
// reset values and timing
// ****************************************
`define PSRFS_ENABLE_RST    8'h00
`define PSRFS_CTRL_RST      8'h00
`define PSRFS_CYCLE_COUNT   3
`define PSRFS_CLK_HZ        40000000
`define PSRFS_UV_MS         128
`define PSRFS_SHORT_MS      64
// 128 ms and 64 ms of the 40 MHz clock, sized to the timer width
`define PSRFS_UV_CYCLES     24'h4E_2000
`define PSRFS_SHORT_CYCLES  24'h27_1000

`endif

// >>> verilog/psrfs_timer.v
// continuous-condition millisecond timer
`timescale 1ns/1ps

module psrfs_timer
#(
  parameter WIDTH = 24,
  parameter [WIDTH-1:0] LIMIT = 24'h00_0010
)
(
  input  wire             clk,
  input  wire             srst,
  input  wire             clr,
  input  wire             cond,
  output reg              hit
);

  reg [WIDTH-1:0] cnt_ff;
  reg [WIDTH-1:0] nxt_cnt;

  always @*
  begin
    nxt_cnt = cnt_ff;
    if (clr || !cond)
      nxt_cnt = {WIDTH{1'b0}};
    else if (cnt_ff != LIMIT)
      nxt_cnt = cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      cnt_ff <= {WIDTH{1'b0}};
      hit    <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      // fires on the same edge that the count reaches the limit, still only while cond holds
      hit    <= cond && !clr && (nxt_cnt == LIMIT);
    end
  end

endmodule // psrfs_timer

// >>> verilog/psrfs_top.v
// fault supervisor for a primary-side regulated flyback switcher
`timescale 1ns/1ps
`include "psrfs_map.vh"

// How it works
// RULE_01 - ov on three cycles: stop, recover
// RULE_02 - uv held 128ms: stop, recover
// RULE_03 - short level held 64ms: stop, recover
// RULE_04 - cs max three pulses: stop, recover
// RULE_05 - overtemp stops drive at once
// RULE_06 - no pulse until overtemp clears
// RULE_07 - bus sampled each primary on-time
// RULE_08 - one check pulse at start level
// RULE_09 - failed check waits for supply minimum
// RULE_10 - brown-out three cycles: stop, recover
// RULE_11 - recovery restarts at supply minimum
// RULE_12 - supply overvoltage stops drive at once
// RULE_13 - counters and timers clear on restart
module psrfs_top
#(
  parameter        TMR_W        = 24,
  parameter [23:0] UV_CYCLES    = `PSRFS_UV_CYCLES,
  parameter [23:0] SHORT_CYCLES = `PSRFS_SHORT_CYCLES
)
(
  input  wire       CLK,
  input  wire       SRST,
  input  wire       CYCLE_END,
  input  wire       OV_CMP,
  input  wire       UV_CMP,
  input  wire       SHORT_CMP,
  input  wire       CS_MAX_CMP,
  input  wire       BUS_SAMPLE_VALID,
  input  wire       BROWN_IN_CMP,
  input  wire       BROWN_OUT_CMP,
  input  wire       OTP_FLAG,
  input  wire       SUPPLY_OV_FLAG,
  input  wire       SUPPLY_START,
  input  wire       SUPPLY_MIN,
  input  wire [3:0] REG_ADDR,
  input  wire [7:0] REG_WDATA,
  input  wire       REG_WR,
  input  wire       REG_RD,
  output reg  [7:0] REG_RDATA,
  output reg        DRIVE_EN,
  output reg        CHECK_PULSE,
  output reg        IRQ
);

  // ****************************************
  // states
  // ****************************************
  localparam [2:0] ST_OFF   = 3'h0;
  localparam [2:0] ST_CHECK = 3'h1;
  localparam [2:0] ST_RUN   = 3'h2;
  localparam [2:0] ST_HOLD  = 3'h3;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [1:0] ov_cnt_ff;
  reg [1:0] sat_cnt_ff;
  reg [1:0] bo_cnt_ff;
  reg [7:0] status_ff;
  reg [7:0] enable_ff;
  reg [7:0] last_ff;
  reg       otp_latch_ff;
  reg [7:0] ev;
  reg       nxt_drive_en;
  reg       nxt_check_pulse;
  reg [7:0] nxt_rdata;
  wire      fault_any;
  wire      clr_wr;
  wire      en_wr;
  wire      uv_hit;
  wire      short_hit;
  wire      restart;
  wire      running;

  // counts consecutive failing cycles, saturating at the limit
  function [1:0] cyc_next;
    input [1:0] cnt;
    input       tick;
    input       fail;
    begin
      if (!tick)
        cyc_next = cnt;
      else if (!fail)
        cyc_next = 2'h0;
      else if (cnt != 2'h3)
        cyc_next = cnt + 2'h1;
      else
        cyc_next = cnt;
    end
  endfunction

  // one write strobe qualified by one register offset
  function wr_hit;
    input       wr;
    input [3:0] addr;
    input [3:0] target;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  assign running   = (state_ff == ST_RUN);
  assign fault_any = (ev != 8'h00);
  assign clr_wr    = wr_hit(REG_WR, REG_ADDR, `PSRFS_REG_CLEAR);
  assign en_wr     = wr_hit(REG_WR, REG_ADDR, `PSRFS_REG_ENABLE);
  assign restart = (state_ff != ST_RUN) && (nxt_state == ST_CHECK);

  // ****************************************
  // millisecond timers
  // ****************************************
  psrfs_timer #(.WIDTH(TMR_W), .LIMIT(UV_CYCLES)) u_uv_tmr
  (
    .clk  (CLK),
    .srst (SRST),
    .clr  (!running),
    .cond (UV_CMP),
    .hit  (uv_hit)
  ); // RULE_02 RULE_13

  psrfs_timer #(.WIDTH(TMR_W), .LIMIT(SHORT_CYCLES)) u_short_tmr
  (
    .clk  (CLK),
    .srst (SRST),
    .clr  (!running),
    .cond (SHORT_CMP),
    .hit  (short_hit)
  ); // RULE_03 RULE_13

  // ****************************************
  // fault events
  // ****************************************
  always @*
  begin
    ev = 8'h00;
    ev[`PSRFS_EV_OVP]      = running && CYCLE_END && OV_CMP && (ov_cnt_ff == 2'h2); // RULE_01
    ev[`PSRFS_EV_UVP]      = running && uv_hit; // RULE_02
    ev[`PSRFS_EV_SHORT]    = running && short_hit; // RULE_03
    ev[`PSRFS_EV_SAT]      = running && CYCLE_END && CS_MAX_CMP && (sat_cnt_ff == 2'h2); // RULE_04
    ev[`PSRFS_EV_OTP]      = OTP_FLAG && (state_ff != ST_HOLD); // RULE_05
    ev[`PSRFS_EV_OUTPUT_OVERVOLTAGE_PROTECT]     = SUPPLY_OV_FLAG && (state_ff != ST_HOLD); // RULE_12
    ev[`PSRFS_EV_BROWNOUT] = running && BUS_SAMPLE_VALID && BROWN_OUT_CMP
                             && (bo_cnt_ff == 2'h2); // RULE_10
    ev[`PSRFS_EV_BROWNIN]  = (state_ff == ST_CHECK) && BUS_SAMPLE_VALID && !BROWN_IN_CMP; // RULE_09
  end

  // ****************************************
  // supervisor state machine
  // ****************************************
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF:
        if (SUPPLY_START && !otp_latch_ff && !OTP_FLAG && !SUPPLY_OV_FLAG)
          nxt_state = ST_CHECK; // RULE_06 RULE_08
      ST_CHECK:
        if (ev != 8'h00)
          nxt_state = ST_HOLD; // RULE_09
        else if (BUS_SAMPLE_VALID)
          nxt_state = ST_RUN; // RULE_08
      ST_RUN:
        if (ev != 8'h00)
          nxt_state = ST_HOLD;
      ST_HOLD:
        if (SUPPLY_MIN)
          nxt_state = ST_OFF; // RULE_11
      default:
        nxt_state = ST_OFF;
    endcase
  end

  always @(posedge CLK)
  begin
    if (SRST)
      state_ff <= ST_OFF;
    else
      state_ff <= nxt_state;
  end

  // ****************************************
  // consecutive-cycle counters
  // ****************************************
  always @(posedge CLK)
  begin
    if (SRST || restart || !running)
    begin
      ov_cnt_ff  <= 2'h0; // RULE_13
      sat_cnt_ff <= 2'h0; // RULE_13
      bo_cnt_ff  <= 2'h0; // RULE_13
    end
    else
    begin
      ov_cnt_ff  <= cyc_next(ov_cnt_ff, CYCLE_END, OV_CMP); // RULE_01 RULE_13
      sat_cnt_ff <= cyc_next(sat_cnt_ff, CYCLE_END, CS_MAX_CMP); // RULE_04 RULE_13
      // the bus sample is taken in primary on-time, so it ticks its own counter
      bo_cnt_ff  <= cyc_next(bo_cnt_ff, BUS_SAMPLE_VALID, BROWN_OUT_CMP); // RULE_07 RULE_10
    end
  end

  // ****************************************
  // overtemperature hold-off
  // ****************************************
  always @(posedge CLK)
  begin
    if (SRST)
      otp_latch_ff <= 1'b0;
    else
      // one cycle late, so a flag that just dropped still blocks a start
      otp_latch_ff <= OTP_FLAG; // RULE_05 RULE_06
  end

  // ****************************************
  // gate-drive outputs
  // ****************************************
  always @*
  begin
    nxt_drive_en    = (nxt_state == ST_RUN) || (nxt_state == ST_CHECK); // RULE_05 RULE_12
    nxt_check_pulse = (nxt_state == ST_CHECK); // RULE_08
  end

  // taken from the next state so a fault drops drive on its own edge
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      DRIVE_EN    <= 1'b0;
      CHECK_PULSE <= 1'b0;
    end
    else
    begin
      DRIVE_EN    <= nxt_drive_en;
      CHECK_PULSE <= nxt_check_pulse;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  always @*
  begin
    nxt_rdata = 8'h00;
    if (REG_RD)
    begin
      case (REG_ADDR)
        `PSRFS_REG_STATUS: nxt_rdata = status_ff;
        `PSRFS_REG_ENABLE: nxt_rdata = enable_ff;
        `PSRFS_REG_STATE:  nxt_rdata = {4'h0, otp_latch_ff, state_ff};
        `PSRFS_REG_CTRL:   nxt_rdata = last_ff;
        default:           nxt_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge CLK)
  begin
    if (SRST)
    begin
      status_ff <= 8'h00;
      enable_ff <= `PSRFS_ENABLE_RST;
      last_ff   <= 8'h00;
      REG_RDATA <= 8'h00;
    end
    else
    begin
      // set beats a clear arriving in the same cycle
      if (clr_wr)
        status_ff <= (status_ff & ~REG_WDATA) | ev;
      else
        status_ff <= status_ff | ev;
      if (en_wr)
        enable_ff <= REG_WDATA;
      if (fault_any)
        last_ff <= ev;
      // zero outside the read slot keeps a shared bus quiet
      REG_RDATA <= nxt_rdata;
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  // level output, one cycle behind status and enable
  always @(posedge CLK)
  begin
    if (SRST)
      IRQ <= 1'b0;
    else
      IRQ <= |(status_ff & enable_ff);
  end

endmodule // psrfs_top

// >>> tb/psrfs_analog.sv
// switching-cycle strobe model for the fault supervisor
`timescale 1ns/1ps
// ********************
// switching cycle model
// ********************
module psrfs_analog
(
  input  wire  clk,
  input  wire  srst,
  input  wire  drive,
  output logic cyc_end = 1'b0,
  output logic bus_valid = 1'b0
);
  logic [1:0] ph_ff = 2'h0;
  // no strobes while the gate is idle, as a stopped converter makes none
  always @(posedge clk)
  begin
    ph_ff     <= (srst || !drive) ? 2'h0 : ph_ff + 2'h1;
    bus_valid <= !srst && drive && ph_ff == 2'h1;
    cyc_end   <= !srst && drive && ph_ff == 2'h3;
  end
endmodule // psrfs_analog

// >>> tb/psrfs_chk.sv
// assertion checker for the fault supervisor
`timescale 1ns/1ps
module psrfs_chk
(
  input wire       CLK,
  input wire       SRST,
  input wire       CYCLE_END,
  input wire       OV_CMP,
  input wire       CS_MAX_CMP,
  input wire       BUS_SAMPLE_VALID,
  input wire       BROWN_IN_CMP,
  input wire       BROWN_OUT_CMP,
  input wire       OTP_FLAG,
  input wire       SUPPLY_OV_FLAG,
  input wire       SUPPLY_START,
  input wire       REG_RD,
  input wire [7:0] REG_RDATA,
  input wire       DRIVE_EN,
  input wire       CHECK_PULSE,
  input wire       IRQ
);
  // ********************
  // assertions
  // ********************
  default clocking dc @(posedge CLK); endclocking
  default disable iff (SRST);
  // failing-sample run lengths; cleared when drive stops
  logic [1:0] cnt_ff [3];
  wire  [2:0] ev  = {BUS_SAMPLE_VALID, CYCLE_END, CYCLE_END};
  wire  [2:0] bad = {BROWN_OUT_CMP, CS_MAX_CMP, OV_CMP};
  always @(posedge CLK)
    for (int i = 0; i < 3; i++)
      if (SRST || !DRIVE_EN) cnt_ff[i] <= 2'h0;
      else if (ev[i]) cnt_ff[i] <= bad[i] ? cnt_ff[i] + 2'h1 : 2'h0;
  a_ov_stop: assert property (CYCLE_END && OV_CMP && cnt_ff[0] == 2'h2 |=> !DRIVE_EN)
    else $error("ov run kept drive");
  a_sat_stop: assert property (CYCLE_END && CS_MAX_CMP && cnt_ff[1] == 2'h2 |=> !DRIVE_EN)
    else $error("cs run kept drive");
  a_bo_stop: assert property (ev[2] && BROWN_OUT_CMP && cnt_ff[2] == 2'h2 |=> !DRIVE_EN)
    else $error("brown-out kept drive");
  a_otp_stop: assert property (OTP_FLAG |=> !DRIVE_EN && !CHECK_PULSE)
    else $error("overtemp kept drive");
  a_sov_stop: assert property (SUPPLY_OV_FLAG |=> !DRIVE_EN)
    else $error("supply ov kept drive");
  a_bi_fail: assert property (CHECK_PULSE && ev[2] && !BROWN_IN_CMP |=> !DRIVE_EN [*4])
    else $error("failed check drove on");
  a_start_gate: assert property (!DRIVE_EN && !SUPPLY_START |=> !DRIVE_EN)
    else $error("drive without start");
  a_rd_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside slot");
  cover property (CYCLE_END && OV_CMP && cnt_ff[0] == 2'h2);
  cover property (CHECK_PULSE && ev[2] && !BROWN_IN_CMP);
  cover property ($rose(IRQ));
endmodule // psrfs_chk
bind psrfs_top psrfs_chk chk_u (.*);

// >>> tb/psrfs_top_bench.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
module psr_fault_supervisor_bench;
  logic       CLK = 1'b0, SRST = 1'b1, OV_CMP = 1'b0, UV_CMP = 1'b0, SHORT_CMP = 1'b0;
  logic       CS_MAX_CMP = 1'b0, BROWN_IN_CMP = 1'b0, BROWN_OUT_CMP = 1'b0, OTP_FLAG = 1'b0;
  logic       SUPPLY_OV_FLAG = 1'b0, SUPPLY_START = 1'b0, SUPPLY_MIN = 1'b0;
  logic       REG_WR = 1'b0, REG_RD = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [7:0] REG_WDATA = 8'h00;
  wire  [7:0] REG_RDATA;
  wire        CYCLE_END, BUS_SAMPLE_VALID, DRIVE_EN, CHECK_PULSE, IRQ;
  int         bad_count = 0;
  int         compares = 0;
  always #12.5 CLK = ~CLK;
  // short timers keep the run brief
  psrfs_top #(.UV_CYCLES(24'h00_0010), .SHORT_CYCLES(24'h00_0008)) dut_u (.*);
  psrfs_analog ana_u (.clk(CLK), .srst(SRST), .drive(DRIVE_EN | CHECK_PULSE),
    .cyc_end(CYCLE_END), .bus_valid(BUS_SAMPLE_VALID));
  // ********************
  // tasks
  // ********************
  task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    cmp("rdata", e, REG_RDATA);
  endtask
  task wd(input logic v);
    for (int i = 0; i < 100 && DRIVE_EN !== v; i++) tk(1);
  endtask
  // fault lines in event-bit order; index 7 clears all
  task flt(input int k);
    @(posedge CLK);
    {BROWN_OUT_CMP, SUPPLY_OV_FLAG, OTP_FLAG, CS_MAX_CMP, SHORT_CMP, UV_CMP, OV_CMP}
      <= 7'h01 << k;
  endtask
  task rs;
    @(posedge CLK) SUPPLY_MIN <= 1'b1;
    @(posedge CLK) SUPPLY_MIN <= 1'b0;
  endtask
  task finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ********************
  // tests
  // ********************
  initial
  begin
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    rd(4'h2, 8'h00);
    rd(4'hF, 8'h00);
    wr(4'h2, 8'hFF);
    @(posedge CLK) SUPPLY_START <= 1'b1;
    wd(1'b1);
    wd(1'b0);
    rd(4'h0, 8'h80);
    cmp("irq", 8'h01, IRQ);
    tk(20);
    cmp("drive", 8'h00, DRIVE_EN);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h00);
    rd(4'h0, 8'h80);
    cmp("irq", 8'h00, IRQ);
    wr(4'h2, 8'hFF);
    wr(4'h1, 8'hFF);
    rd(4'h0, 8'h00);
    @(posedge CLK) BROWN_IN_CMP <= 1'b1;
    for (int k = 0; k < 7; k++)
    begin
      rs();
      wd(1'b1);
      cmp("check", 8'h01, CHECK_PULSE);
      tk(8);
      cmp("drive", 8'h01, DRIVE_EN);
      cmp("check", 8'h00, CHECK_PULSE);
      // two failing samples, one good one: the run must restart
      if (k == 0 || k == 3 || k == 6)
      begin
        flt(k);
        tk(8);
        flt(7);
        tk(4);
        cmp("drive", 8'h01, DRIVE_EN);
      end
      flt(k);
      if (k == 1 || k == 2)
      begin
        tk(k == 1 ? 14 : 6);
        cmp("drive", 8'h01, DRIVE_EN);
      end
      wd(1'b0);
      cmp("drive", 8'h00, DRIVE_EN);
      rd(4'h0, 8'h01 << k);
      rd(4'h4, 8'h01 << k);
      rd(4'h3, (k == 4) ? 8'h0B : 8'h03);
      if (k == 4)
      begin
        rs();
        tk(20);
        cmp("drive", 8'h00, DRIVE_EN);
      end
      flt(7);
      wr(4'h1, 8'hFF);
    end
    finish_test;
  end
  initial
  begin
    repeat (5000) @(posedge CLK);
    bad_count++;
    finish_test;
  end
endmodule // psr_fault_supervisor_bench
